/* File: src/hppsc_cfg.svh */
`ifndef HPPSC_CFG_SVH
`define HPPSC_CFG_SVH

// core clock rate in kHz (40 ns period)
`define HPPSC_CLK_FREQ_KHZ   25000
// upstream pull-up hold-off time in ms
`define HPPSC_PULLUP_TIME_MS 15
// cycles of the hold-off, derived from time and clock rate
`define HPPSC_PULLUP_CYCLES  (`HPPSC_PULLUP_TIME_MS * `HPPSC_CLK_FREQ_KHZ)
// consecutive low cycles before an overcurrent counts
`define HPPSC_OC_FILTER_CYCLES 8
// number of downstream ports
`define HPPSC_NUM_PORTS      7
// position of each pin in the synchroniser vector below the overcurrent bits
`define HPPSC_SYNC_PWR_SRC   0
`define HPPSC_SYNC_EXT_ROM   1
`define HPPSC_SYNC_ROM_DATA  2
`define HPPSC_SYNC_CLK_MODE  3
`define HPPSC_SYNC_MISC_BITS 4

`endif

/* File: src/hppsc_pkg.sv */
package hppsc_pkg;

  // how the downstream ports are supplied
  typedef enum logic [0:0] {
    HPPSC_BUS_POWERED  = 1'b0,
    HPPSC_SELF_POWERED = 1'b1
  } hppsc_pwr_mode_t;

  // upstream pull-up control states
  typedef enum logic [0:0] {
    HPPSC_PU_FLOAT = 1'b0,
    HPPSC_PU_DRIVE = 1'b1
  } hppsc_pu_state_t;

  // core clock source
  typedef enum logic [0:0] {
    HPPSC_CLK_MULTIPLIER = 1'b0,
    HPPSC_CLK_EXTERNAL   = 1'b1
  } hppsc_clk_src_t;

endpackage : hppsc_pkg

/* File: src/hppsc_oc_filter.sv */
`timescale 1ns/10ps
// glitch filter: a low level must persist before it is reported
module hppsc_oc_filter #(
  parameter int FILTER_CYCLES = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic raw_n,
  output logic      event_q
);

  localparam int CW = $clog2(FILTER_CYCLES + 1);

  logic [CW-1:0] cnt_q;

  // refuse a filter length the counter cannot serve
  if (FILTER_CYCLES < 1)
  begin : g_bad_len
    $error("hppsc_oc_filter: FILTER_CYCLES must be at least 1");
  end

  // count consecutive low samples; any high sample restarts the count
  always_ff @(posedge clk)
  begin
    if (rst || raw_n)
    begin
      cnt_q   <= '0;
      event_q <= 1'b0;
    end
    else if (cnt_q == CW'(FILTER_CYCLES - 1))
    begin
      event_q <= 1'b1; // see [R10] see [R22]
    end
    else
    begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

endmodule : hppsc_oc_filter

/* File: src/hppsc_top.sv */
// Summary of operation
// [R1] low power-source select means bus-powered, high means self-powered ports.
// [R2] board holds the gang strap static; sampled once as configuration.
// [R3] system reset or power-source change floats pull-up and restarts 15 ms count.
// [R4] after the count expires pull-up is driven high until next such event.
// [R5] rom enable strap high disables the serial rom interface and its clock.
// [R6] rom enable strap low drives three-state clock and bidirectional data line.
// [R7] rom enable strap high makes the shared data pin the gang selector.
// [R8] per-port mode gives each of seven ports its own overcurrent input.
// [R9] ganged mode acts on any overcurrent input; board ties them together.
// [R10] every overcurrent input is noise filtered.
// [R11] port power enables are active-low push-pull outputs.
// [R12] hub-configured indicator high while configured, low otherwise.
// [R13] any-port-powered indicator high while at least one port is powered.
// [R14] no-port-disabled indicator high unless some port is disabled.
// [R15] reset at power-up initialises all logic; the two pin synchroniser stages have no reset.
// [R16] system applies a reset pulse of one hundred microseconds to 1 ms.
// [R17] clock runs during at least the last 60 microseconds of reset.
// [R18] mode low selects the clock multiplier, high the external 48-MHz clock.
// [R19] overcurrent turns off power of the affected port, or all when ganged.
// [R20] ganged mode switches all power enables on the same cycle.
// [R21] indicators float while in low-power suspend.
// [R22] filter reports only after a configurable run of low samples.
// [R23] pull-up count comes from the core clock; restart clears partial count.
`timescale 1ns/10ps
`include "hppsc_cfg.svh"
module hppsc_top #(
  parameter int NUM_PORTS      = `HPPSC_NUM_PORTS,
  parameter int FILTER_CYCLES  = `HPPSC_OC_FILTER_CYCLES,
  parameter int PULLUP_CYCLES  = `HPPSC_PULLUP_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  // straps and pins from the board
  input  wire logic                 power_source_select_n,
  input  wire logic                 external_rom_enable_n,
  input  wire logic                 clock_mode_select,
  input  wire logic [NUM_PORTS-1:0] port_overcurrent_n,
  input  wire logic                 serial_rom_data_or_gang_select_i,
  // requests from the hub engine on this clock
  input  wire logic                 hub_configured,
  input  wire logic                 suspend_request,
  input  wire logic [NUM_PORTS-1:0] port_power_request,
  input  wire logic [NUM_PORTS-1:0] port_disabled,
  input  wire logic                 rom_gang_setting,
  input  wire logic                 rom_clock_drive,
  input  wire logic                 rom_clock_level,
  input  wire logic                 rom_data_drive,
  input  wire logic                 rom_data_level,
  // pins to the board
  output logic                      upstream_pullup_enable,
  output logic                      upstream_pullup_enable_oe,
  output logic [NUM_PORTS-1:0]      port_power_enable_n,
  output logic                      hub_configured_indicator,
  output logic                      hub_configured_indicator_oe,
  output logic                      any_port_powered_indicator,
  output logic                      any_port_powered_indicator_oe,
  output logic                      no_port_disabled_indicator,
  output logic                      no_port_disabled_indicator_oe,
  output logic                      suspend_status_out,
  output logic                      serial_rom_clock,
  output logic                      serial_rom_clock_oe,
  output logic                      serial_rom_data_or_gang_select_o,
  output logic                      serial_rom_data_or_gang_select_oe,
  // status back to the hub engine
  output logic                      rom_data_sample,
  output logic                      rom_interface_active,
  output logic                      ganged_mode,
  output logic                      self_powered_mode,
  output logic                      core_clock_external,
  output logic [NUM_PORTS-1:0]      port_overcurrent_status
);

  localparam int SW = NUM_PORTS + `HPPSC_SYNC_MISC_BITS;
  localparam int PW = $clog2(PULLUP_CYCLES + 1);

  // refuse sizes the logic cannot serve
  if (NUM_PORTS < 1 || NUM_PORTS > `HPPSC_NUM_PORTS || PULLUP_CYCLES < 1)
  begin : g_bad_param
    $error("hppsc_top: NUM_PORTS must be 1..7 and PULLUP_CYCLES at least 1");
  end

  logic [SW-1:0]                  sync1_q;
  logic [SW-1:0]                  sync2_q;
  logic                           pwr_src_prev_q;
  logic                           strap_taken_q;
  hppsc_pkg::hppsc_pu_state_t     pu_state_q;
  logic [PW-1:0]                  pu_cnt_q;
  logic [NUM_PORTS-1:0]           oc_filt;
  logic [NUM_PORTS-1:0]           power_d;
  logic                           pwr_src_s;
  logic                           ext_rom_n_s;
  logic                           rom_data_s;
  logic                           clk_mode_s;
  logic                           pwr_src_change;

  // power each requested port unless an overcurrent blocks it; ganged mode uses one shared decision
  function automatic logic [NUM_PORTS-1:0] power_select(
    input logic                 ganged,
    input logic [NUM_PORTS-1:0] request,
    input logic [NUM_PORTS-1:0] oc
  );
    logic [NUM_PORTS-1:0] result;
    if (ganged)
      result = {NUM_PORTS{(|request) & ~(|oc)}}; // see [R9] see [R19] see [R20]
    else
      result = request & ~oc; // see [R8] see [R19]
    return result;
  endfunction : power_select

  // two-stage synchroniser for every board pin; it keeps sampling through reset while the clock
  // runs, so the straps are already settled at the first edge after release
  always_ff @(posedge clk)
  begin
    sync1_q <= {port_overcurrent_n, clock_mode_select, serial_rom_data_or_gang_select_i,
                external_rom_enable_n, power_source_select_n};
    sync2_q <= sync1_q;
  end

  assign pwr_src_s   = sync2_q[`HPPSC_SYNC_PWR_SRC];
  assign ext_rom_n_s = sync2_q[`HPPSC_SYNC_EXT_ROM];
  assign rom_data_s  = sync2_q[`HPPSC_SYNC_ROM_DATA];
  assign clk_mode_s  = sync2_q[`HPPSC_SYNC_CLK_MODE];

  // noise filter on each overcurrent input
  for (genvar i = 0; i < NUM_PORTS; i++)
  begin : g_filter
    hppsc_oc_filter #(
      .FILTER_CYCLES (FILTER_CYCLES)
    ) u_filter (
      .clk     (clk),
      .rst     (rst),
      .raw_n   (sync2_q[`HPPSC_SYNC_MISC_BITS + i]),
      .event_q (oc_filt[i])
    );
  end

  // power-source mode and clock source follow their pins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      self_powered_mode   <= 1'b0;
      core_clock_external <= 1'b0;
      pwr_src_prev_q      <= 1'b0;
    end
    else
    begin
      self_powered_mode   <= (pwr_src_s == hppsc_pkg::HPPSC_SELF_POWERED); // see [R1]
      core_clock_external <= (clk_mode_s == hppsc_pkg::HPPSC_CLK_EXTERNAL); // see [R18]
      pwr_src_prev_q      <= pwr_src_s;
    end
  end

  // the first cycle after release has no valid previous level yet
  assign pwr_src_change = strap_taken_q && (pwr_src_s != pwr_src_prev_q);

  // catch the gang strap once after reset; the rom supplies it when the interface is on
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      strap_taken_q        <= 1'b0;
      ganged_mode          <= 1'b0;
      rom_interface_active <= 1'b0;
    end
    else if (!strap_taken_q)
    begin
      strap_taken_q        <= 1'b1;
      rom_interface_active <= ~ext_rom_n_s; // see [R5] see [R6]
      ganged_mode          <= ext_rom_n_s ? rom_data_s : 1'b0; // see [R2] see [R7]
    end
    else if (rom_interface_active)
    begin
      ganged_mode <= rom_gang_setting;
    end
  end

  // pull-up hold-off: float, count, then drive high
  always_ff @(posedge clk)
  begin
    if (rst || pwr_src_change)
    begin
      pu_state_q <= hppsc_pkg::HPPSC_PU_FLOAT; // see [R3] see [R15]
      pu_cnt_q   <= '0; // see [R23]
    end
    else if (pu_state_q == hppsc_pkg::HPPSC_PU_FLOAT)
    begin
      if (pu_cnt_q == PW'(PULLUP_CYCLES - 1))
        pu_state_q <= hppsc_pkg::HPPSC_PU_DRIVE; // see [R4]
      else
        pu_cnt_q <= pu_cnt_q + PW'(1); // see [R23]
    end
  end

  assign upstream_pullup_enable    = pu_state_q;
  assign upstream_pullup_enable_oe = pu_state_q;

  assign power_d = power_select(ganged_mode, port_power_request, oc_filt);

  // push-pull active-low power enables, all off in reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      port_power_enable_n     <= {NUM_PORTS{1'b1}};
      port_overcurrent_status <= '0;
    end
    else
    begin
      port_power_enable_n     <= ~power_d; // see [R11]
      port_overcurrent_status <= ganged_mode ? {NUM_PORTS{|oc_filt}} : oc_filt;
    end
  end

  // status indicators, floated during suspend
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hub_configured_indicator      <= 1'b0;
      any_port_powered_indicator    <= 1'b0;
      no_port_disabled_indicator    <= 1'b1;
      hub_configured_indicator_oe   <= 1'b1;
      any_port_powered_indicator_oe <= 1'b1;
      no_port_disabled_indicator_oe <= 1'b1;
      suspend_status_out            <= 1'b0;
    end
    else
    begin
      hub_configured_indicator      <= hub_configured; // see [R12]
      any_port_powered_indicator    <= |power_d; // see [R13]
      no_port_disabled_indicator    <= ~(|port_disabled); // see [R14]
      hub_configured_indicator_oe   <= ~suspend_request; // see [R21]
      any_port_powered_indicator_oe <= ~suspend_request; // see [R21]
      no_port_disabled_indicator_oe <= ~suspend_request; // see [R21]
      suspend_status_out            <= suspend_request;
    end
  end

  // serial rom pins: three-state clock and bidirectional data only when enabled
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      serial_rom_clock                  <= 1'b0;
      serial_rom_clock_oe               <= 1'b0;
      serial_rom_data_or_gang_select_o  <= 1'b0;
      serial_rom_data_or_gang_select_oe <= 1'b0;
      rom_data_sample                   <= 1'b0;
    end
    else
    begin
      serial_rom_clock                  <= rom_interface_active & rom_clock_level; // see [R6]
      serial_rom_clock_oe               <= rom_interface_active & rom_clock_drive; // see [R5] see [R6]
      serial_rom_data_or_gang_select_o  <= rom_interface_active & rom_data_level; // see [R6]
      serial_rom_data_or_gang_select_oe <= rom_interface_active & rom_data_drive; // see [R5] see [R6]
      rom_data_sample                   <= rom_interface_active & rom_data_s;
    end
  end

endmodule : hppsc_top

/* File: tb/hppsc_board.sv */
`timescale 1ns/10ps
// power switches and strap resistor that sit on the hub's port pins
module hppsc_board #(
  parameter int NUM_PORTS = 7
) (
  input  wire logic [NUM_PORTS-1:0] overload,
  input  wire logic                 tie_all,
  input  wire logic                 gang_strap,
  input  wire logic                 data_oe,
  input  wire logic                 data_o,
  input  wire logic [NUM_PORTS-1:0] power_enable_n,
  output logic      [NUM_PORTS-1:0] overcurrent_n,
  output logic      [NUM_PORTS-1:0] port_on,
  output logic                      data_pin
);
  // fault flags, wired into one line when the board gangs them
  assign overcurrent_n = tie_all ? {NUM_PORTS{~|overload}} : ~overload;
  // a switch conducts while its enable is held low
  assign port_on = ~power_enable_n;
  // shared pin: device drive, else the static strap resistor
  assign data_pin = data_oe ? data_o : gang_strap;
endmodule : hppsc_board

/* File: tb/hppsc_top_assertions.sv */
`timescale 1ns/10ps
module hppsc_chk #(
  parameter int NUM_PORTS     = 7,
  parameter int FILTER_CYCLES = 8,
  parameter int PULLUP_CYCLES = 375000
) (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 clock_mode_select,
  input wire logic                 power_source_select_n,
  input wire logic [NUM_PORTS-1:0] port_overcurrent_n,
  input wire logic                 upstream_pullup_enable,
  input wire logic                 upstream_pullup_enable_oe,
  input wire logic [NUM_PORTS-1:0] port_power_enable_n,
  input wire logic                 any_port_powered_indicator,
  input wire logic                 hub_configured_indicator_oe,
  input wire logic                 suspend_status_out,
  input wire logic                 serial_rom_clock_oe,
  input wire logic                 serial_rom_data_or_gang_select_oe,
  input wire logic                 rom_interface_active,
  input wire logic                 ganged_mode,
  input wire logic                 self_powered_mode,
  input wire logic                 core_clock_external,
  input wire logic [NUM_PORTS-1:0] port_overcurrent_status
);
  int lo_cnt;
  int run_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // edges spent floating, and edges with any overcurrent pin low
  always_ff @(posedge clk)
  begin
    lo_cnt  <= (rst || upstream_pullup_enable_oe) ? 0 : lo_cnt + 1;
    run_cnt <= (rst || &port_overcurrent_n) ? 0 : run_cnt + 1;
  end
  // the enables lag the mode by one edge, so only a settled ganged mode is judged
  gang_sync_a: assert property (ganged_mode && $past(ganged_mode) |->
    (&port_power_enable_n || ~|port_power_enable_n))
    else $error("ganged power enables differ");
  oc_off_a: assert property ((port_overcurrent_status & ~port_power_enable_n) == '0)
    else $error("port powered during overcurrent");
  any_pwr_a: assert property (any_port_powered_indicator == !(&port_power_enable_n))
    else $error("powered indicator wrong");
  led_float_a: assert property (suspend_status_out != hub_configured_indicator_oe)
    else $error("indicator drive wrong in suspend");
  rom_off_a: assert property (!rom_interface_active |->
    !serial_rom_clock_oe && !serial_rom_data_or_gang_select_oe)
    else $error("rom pins driven while off");
  pu_time_a: assert property ($rose(upstream_pullup_enable_oe) |-> lo_cnt >= PULLUP_CYCLES)
    else $error("pull-up released early");
  pu_high_a: assert property (upstream_pullup_enable_oe |-> upstream_pullup_enable)
    else $error("pull-up driven low");
  filt_run_a: assert property ($rose(|port_overcurrent_status) |-> run_cnt >= FILTER_CYCLES + 2)
    else $error("overcurrent passed filter too soon");
  clk_src_a: assert property ($stable(clock_mode_select)[*4] |->
    core_clock_external == clock_mode_select)
    else $error("clock source wrong");
  pwr_src_a: assert property ($stable(power_source_select_n)[*4] |->
    self_powered_mode == power_source_select_n)
    else $error("power mode wrong");
  cover property ($rose(upstream_pullup_enable_oe));
  cover property ($rose(|port_overcurrent_status));
  cover property ($fell(hub_configured_indicator_oe));
  cover property ($rose(serial_rom_clock_oe));
endmodule : hppsc_chk
bind hppsc_top hppsc_chk #(.NUM_PORTS(NUM_PORTS), .FILTER_CYCLES(FILTER_CYCLES),
  .PULLUP_CYCLES(PULLUP_CYCLES)) u_chk (.*);

/* File: tb/hppsc_top_tb_top.sv */
`timescale 1ns/10ps
module hppsc_top_tb_top;
  localparam int NP = 7;
  localparam int FC = 3;
  localparam int PC = 40;
  logic clk, rst, power_source_select_n, external_rom_enable_n, clock_mode_select, tie_all, gang_strap;
  logic hub_configured, suspend_request, rom_gang_setting, rom_clock_drive, rom_clock_level;
  logic rom_data_drive, rom_data_level, serial_rom_data_or_gang_select_i, upstream_pullup_enable;
  logic upstream_pullup_enable_oe, hub_configured_indicator, hub_configured_indicator_oe;
  logic any_port_powered_indicator, any_port_powered_indicator_oe, no_port_disabled_indicator;
  logic no_port_disabled_indicator_oe, suspend_status_out, serial_rom_clock, serial_rom_clock_oe;
  logic serial_rom_data_or_gang_select_o, serial_rom_data_or_gang_select_oe, rom_data_sample;
  logic rom_interface_active, ganged_mode, self_powered_mode, core_clock_external;
  logic [NP-1:0] port_overcurrent_n, port_power_request, port_disabled, port_power_enable_n;
  logic [NP-1:0] port_overcurrent_status, overload, port_on;
  int n_errors, tests_run, cyc;

  hppsc_top #(.FILTER_CYCLES(FC), .PULLUP_CYCLES(PC)) DUT (.*);
  hppsc_board #(.NUM_PORTS(NP)) u_board (.overload(overload), .tie_all(tie_all), .gang_strap(gang_strap),
    .data_oe(serial_rom_data_or_gang_select_oe), .data_o(serial_rom_data_or_gang_select_o),
    .power_enable_n(port_power_enable_n), .overcurrent_n(port_overcurrent_n), .port_on(port_on),
    .data_pin(serial_rom_data_or_gang_select_i));

  // free-running core clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      test_done();
    end
  end

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic t_pullup;
    int n;
    n = 0;
    step(20);
    check(upstream_pullup_enable_oe, 1'b0);
    check(port_power_enable_n, 7'h7F);
    check(no_port_disabled_indicator, 1'b1);
    // pulse shortened to 20 cycles for simulation; the clock runs throughout it
    rst = 1'b0;
    while (upstream_pullup_enable_oe !== 1'b1 && n < 2 * PC)
    begin
      step(1);
      n++;
    end
    check(n, PC);
    check(upstream_pullup_enable, 1'b1);
    check({rom_interface_active, serial_rom_clock_oe, serial_rom_data_or_gang_select_oe}, 3'h0);
    check(ganged_mode, 1'b1);
    step(PC);
    check(upstream_pullup_enable_oe, 1'b1);
    $display("test pullup done");
  endtask : t_pullup

  task automatic t_source;
    power_source_select_n = 1'b1;
    step(4);
    check(self_powered_mode, 1'b1);
    check(upstream_pullup_enable_oe, 1'b0);
    step(PC / 2);
    power_source_select_n = 1'b0;
    step(4);
    check(self_powered_mode, 1'b0);
    step(PC - 6);
    check(upstream_pullup_enable_oe, 1'b0);
    step(6);
    check(upstream_pullup_enable_oe, 1'b1);
    $display("test source done");
  endtask : t_source

  task automatic t_power;
    port_power_request = 7'h08;
    step(1);
    check(port_power_enable_n, 7'h00);
    check(port_on, 7'h7F);
    check(any_port_powered_indicator, 1'b1);
    port_power_request = 7'h00;
    step(1);
    check(port_power_enable_n, 7'h7F);
    check(any_port_powered_indicator, 1'b0);
    $display("test power done");
  endtask : t_power

  task automatic t_overcurrent;
    port_power_request = 7'h7F;
    step(1);
    overload = 7'h20;
    step(FC - 1);
    overload = 7'h00;
    step(FC + 4);
    check(port_power_enable_n, 7'h00);
    check(port_overcurrent_status, 7'h00);
    overload = 7'h20;
    step(FC + 2);
    check(port_power_enable_n, 7'h00);
    step(2);
    check(port_power_enable_n, 7'h7F);
    check(port_overcurrent_status, 7'h7F);
    overload = 7'h00;
    step(5);
    check(port_power_enable_n, 7'h00);
    $display("test overcurrent done");
  endtask : t_overcurrent

  task automatic t_leds;
    hub_configured = 1'b1;
    port_disabled = 7'h40;
    step(1);
    check(hub_configured_indicator, 1'b1);
    check(no_port_disabled_indicator, 1'b0);
    suspend_request = 1'b1;
    step(1);
    check({hub_configured_indicator_oe, any_port_powered_indicator_oe, no_port_disabled_indicator_oe}, 3'h0);
    check(suspend_status_out, 1'b1);
    hub_configured = 1'b0;
    port_disabled = 7'h00;
    suspend_request = 1'b0;
    step(1);
    check({hub_configured_indicator_oe, any_port_powered_indicator_oe, no_port_disabled_indicator_oe}, 3'h7);
    check({hub_configured_indicator, no_port_disabled_indicator}, 2'h1);
    check(suspend_status_out, 1'b0);
    $display("test indicators done");
  endtask : t_leds

  task automatic t_clock;
    clock_mode_select = 1'b1;
    step(3);
    check(core_clock_external, 1'b1);
    clock_mode_select = 1'b0;
    step(3);
    check(core_clock_external, 1'b0);
    $display("test clock done");
  endtask : t_clock

  // mid-run reset with new straps, held long enough for them to pass the synchroniser
  task automatic reset_with(input logic rom_n, input logic strap);
    rst = 1'b1;
    external_rom_enable_n = rom_n;
    gang_strap = strap;
    tie_all = strap;
    step(4);
    check(upstream_pullup_enable_oe, 1'b0);
    check(port_power_enable_n, 7'h7F);
    rst = 1'b0;
    step(2);
  endtask : reset_with

  // per-port mode from a low strap: only the faulty port loses power
  task automatic t_per_port;
    reset_with(1'b1, 1'b0);
    check(ganged_mode, 1'b0);
    check(rom_interface_active, 1'b0);
    check(port_power_enable_n, 7'h00);
    overload = 7'h04;
    step(FC + 4);
    check(port_power_enable_n, 7'h04);
    check(port_overcurrent_status, 7'h04);
    check(any_port_powered_indicator, 1'b1);
    overload = 7'h00;
    step(5);
    check(port_power_enable_n, 7'h00);
    $display("test per-port done");
  endtask : t_per_port

  // rom interface on: pins follow the engine and the data pin loops back
  task automatic t_rom;
    reset_with(1'b0, 1'b0);
    check(rom_interface_active, 1'b1);
    check(ganged_mode, 1'b0);
    rom_gang_setting = 1'b1;
    rom_clock_level = 1'b1;
    rom_data_level = 1'b1;
    step(4);
    check(ganged_mode, 1'b1);
    check({serial_rom_clock_oe, serial_rom_clock}, 2'h3);
    check({serial_rom_data_or_gang_select_oe, serial_rom_data_or_gang_select_o}, 2'h3);
    check(rom_data_sample, 1'b1);
    rom_clock_drive = 1'b0;
    rom_data_drive = 1'b0;
    step(4);
    check({serial_rom_clock_oe, serial_rom_data_or_gang_select_oe, rom_data_sample}, 3'h0);
    $display("test rom done");
  endtask : t_rom

  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // main sequence
  initial
  begin
    {n_errors, tests_run, cyc} = '0;
    {rst, tie_all, external_rom_enable_n, rom_clock_drive, rom_data_drive} = 5'h1F;
    {power_source_select_n, clock_mode_select, hub_configured, suspend_request} = 4'h0;
    {rom_gang_setting, rom_clock_level, rom_data_level} = 3'h0;
    gang_strap = 1'b1;
    port_power_request = 7'h7F;
    port_disabled = 7'h00;
    overload = 7'h00;
    t_pullup();
    t_source();
    t_power();
    t_overcurrent();
    t_leds();
    t_clock();
    t_per_port();
    t_rom();
    test_done();
  end
endmodule : hppsc_top_tb_top
